/* verilog/cmrc_top.v */
/*
 * clock mode decoding and clock ratio register.
 * assumes: mode pins are board straps, held steady; a watchdog elsewhere
 * reports its overflow as a one-cycle pulse on this clock; analog plls,
 * oscillator and clock pause handshake live outside this block.
 */
// Implementation choice: the plain strobed port.
// Overview of operation
// - mode 5 runs pll1 only and applies quarter-cycle lag on clock path.
// - mode 5 with pll1 disabled drops the quarter-cycle phase shift.
// - mode 6 runs no pll; internal clocks come straight from clock pin.
// - in modes 4-6 the pin clock may change rate or stop.
// - modes 0-3 take clock on crystal input; select pin picks driven or crystal.
// - modes 4-6 take clock pin input; select pin becomes pause request.
// - core, bus, periph clock ratios come from ratio field via three dividers.
// - only power-on reset initialises the ratio register, not watchdog reset.
// - power-on loads 00 for modes 0,1; 40 for mode 2; 60 for mode 3.
// - power-on loads a6 for modes 4,5 and e0 for mode 6.
// - bit7 pll2 disable, bit6 pll1 disable, bit5 tristate, bit4 reserved, 3:0 ratio.
// - bit7 writable modes 0-3; reads 1 in modes 4-6.
// - bit6 writable modes 0,1,4,5; reads 1 in modes 2,3,6.
// - bit5 writable modes 0-3, 0 drives pin; reads 1 in modes 4-6.
// - reserved bit 4 reads 0; software writes 0.
// - software writes only ratio codes legal for mode and pll state.
// - both plls off: code 0000 gives quarter rate, 1111 full rate.
// - new ratio applies at watchdog overflow, which then raises no flags.
`timescale 1ns/10ps
`include "cmrc_map.vh"

module cmrc_top #(
  parameter ADDR_W = `CMRC_ADDR_W
) (
  input wire clock,
  input wire rst_n,
  input wire [2:0] mode_select_pins,
  input wire pause_req_or_osc_select,
  input wire wdt_overflow,
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg [2:0] clock_mode,
  output reg pll1_run,
  output reg pll2_run,
  output reg phase_lag_en,
  output reg clk_from_pin,
  output reg crystal_osc_en,
  output reg ext_clock_driven,
  output reg clock_pause_req,
  output reg clkout_drive_en,
  output reg [1:0] core_divider,
  output reg [1:0] bus_divider,
  output reg [1:0] periph_divider,
  output reg [1:0] pll2_mult,
  output reg ratio_change_pending,
  output reg wdt_start,
  output reg wdt_flag_suppress
);

  // ==========================================================
  // pin synchronisers
  reg [2:0] mode_s1_r;
  reg [2:0] mode_s2_r;
  reg sel_s1_r;
  reg sel_s2_r;

  always @(posedge clock) begin
    mode_s1_r <= mode_select_pins;
    mode_s2_r <= mode_s1_r;
    sel_s1_r <= pause_req_or_osc_select;
    sel_s2_r <= sel_s1_r;
  end

  // ==========================================================
  // mode decode helpers
  function pin_clock_mode;
    input [2:0] m;
    begin
      pin_clock_mode = m[2];
    end
  endfunction

  function pll2_fixed;
    input [2:0] m;
    begin
      pll2_fixed = m[2];
    end
  endfunction

  function pll1_fixed;
    input [2:0] m;
    begin
      pll1_fixed = (m == `CMRC_MODE2) || (m == `CMRC_MODE3) || (m == `CMRC_MODE6);
    end
  endfunction

  function [7:0] init_value;
    input [2:0] m;
    begin
      case (m)
        `CMRC_MODE0, `CMRC_MODE1: init_value = `CMRC_INIT_M01;
        `CMRC_MODE2: init_value = `CMRC_INIT_M2;
        `CMRC_MODE3: init_value = `CMRC_INIT_M3;
        `CMRC_MODE4, `CMRC_MODE5: init_value = `CMRC_INIT_M45;
        `CMRC_MODE6: init_value = `CMRC_INIT_M6;
        default: init_value = `CMRC_INIT_M6;
      endcase
    end
  endfunction

  // divider code: 0 = x1, 1 = x1/2, 2 = x1/4 of the pll1 stage output
  function [1:0] div_code;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: div_code = 2'h2;
        2'h1: div_code = 2'h1;
        default: div_code = 2'h0;
      endcase
    end
  endfunction

  // ==========================================================
  // power-on sequencing
  // the straps are caught one synchroniser delay after release, so the
  // register loads its mode value two cycles after rst_n goes high
  reg [1:0] por_cnt_r;
  reg mode_valid_r;
  reg [2:0] mode_r;

  always @(posedge clock) begin
    if (!rst_n) begin
      por_cnt_r <= 2'h0;
      mode_valid_r <= 1'b0;
      mode_r <= `CMRC_MODE0;
    end else if (!mode_valid_r) begin
      por_cnt_r <= por_cnt_r + 2'h1;
      if (por_cnt_r == `CMRC_POR_LOAD_CNT) begin
        mode_valid_r <= 1'b1;
        mode_r <= mode_s2_r;
      end
    end
  end

  // ==========================================================
  // clock ratio register: rst_n is the power-on reset pin; the watchdog
  // reset never reaches this flop, so its contents survive it
  reg [7:0] ratio_r;
  reg [7:0] ratio_nxt;
  reg [7:0] active_r;
  reg pending_r;
  wire hit;
  wire wr_hit;
  wire [2:0] m;

  assign hit = (reg_addr == `CMRC_RATIO_ADDR);
  assign wr_hit = reg_wr && hit && mode_valid_r;
  assign m = mode_r;

  always @* begin
    ratio_nxt = ratio_r;
    if (wr_hit) begin
      ratio_nxt[`CMRC_RATIO_MSB:`CMRC_RATIO_LSB] = reg_wdata[3:0];
      ratio_nxt[`CMRC_BIT_RSVD] = 1'b0;
      if (!pll2_fixed(m))
        ratio_nxt[`CMRC_BIT_PLL2_DIS] = reg_wdata[`CMRC_BIT_PLL2_DIS];
      if (!pll1_fixed(m))
        ratio_nxt[`CMRC_BIT_PLL1_DIS] = reg_wdata[`CMRC_BIT_PLL1_DIS];
      if (!pin_clock_mode(m))
        ratio_nxt[`CMRC_BIT_CLKOUT_TRI] = reg_wdata[`CMRC_BIT_CLKOUT_TRI];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      ratio_r <= 8'h00;
      active_r <= 8'h00;
      pending_r <= 1'b0;
    end else if (!mode_valid_r) begin
      if (por_cnt_r == `CMRC_POR_LOAD_CNT) begin
        ratio_r <= init_value(mode_s2_r);
        active_r <= init_value(mode_s2_r);
      end
    end else begin
      // fixed bits are forced each cycle so they always read 1
      ratio_r <= ratio_nxt | {pll2_fixed(m), pll1_fixed(m), pin_clock_mode(m), 5'h00};
      // a write landing on the overflow edge keeps the change pending, so
      // the new value waits for the next overflow instead of being lost
      if (wr_hit)
        pending_r <= 1'b1;
      else if (wdt_overflow && pending_r) begin
        pending_r <= 1'b0;
        active_r <= ratio_r;
      end
    end
  end

  // ==========================================================
  // clock plan from the applied register copy
  wire p1_on;
  wire p2_on;
  wire [3:0] fr;

  assign p1_on = !active_r[`CMRC_BIT_PLL1_DIS] && !pll1_fixed(m);
  assign p2_on = !active_r[`CMRC_BIT_PLL2_DIS] && !pll2_fixed(m);
  assign fr = active_r[`CMRC_RATIO_MSB:`CMRC_RATIO_LSB];

  // ==========================================================
  // clock source selection
  // nothing is claimed until the straps are latched, so a pin-clock board
  // never sees the crystal path or the pause request flicker after reset
  reg from_pin_nxt;
  reg crystal_nxt;
  reg driven_nxt;
  reg pause_nxt;

  always @* begin
    from_pin_nxt = 1'b0;
    crystal_nxt = 1'b0;
    driven_nxt = 1'b0;
    pause_nxt = 1'b0;
    if (mode_valid_r) begin
      from_pin_nxt = pin_clock_mode(m);
      crystal_nxt = !pin_clock_mode(m) && sel_s2_r;
      driven_nxt = !pin_clock_mode(m) && !sel_s2_r;
      // pause request only forwarded; a stopped or retimed pin clock is handled outside
      pause_nxt = pin_clock_mode(m) && sel_s2_r;
    end
  end

  // ==========================================================
  // divider selection from the applied ratio field
  // the generic mapping counts from the pll stage output; with both plls
  // halted the all-ones code must give full rate, which the mapping alone
  // would not, so the two end codes are pinned explicitly
  reg [1:0] core_div_nxt;
  reg [1:0] bus_div_nxt;
  reg [1:0] periph_div_nxt;
  wire plls_off;

  assign plls_off = !p1_on && !p2_on;

  always @* begin
    core_div_nxt = div_code(fr[3:2]);
    bus_div_nxt = div_code({fr[3] & fr[2], !(fr[3] & fr[2]) & (fr[1] | fr[0])});
    periph_div_nxt = div_code({1'b0, fr[1]});
    if (plls_off && fr == `CMRC_RATIO_UNITY) begin
      core_div_nxt = 2'h0;
      bus_div_nxt = 2'h0;
      periph_div_nxt = 2'h0;
    end else if (plls_off && fr == `CMRC_RATIO_QUARTER) begin
      core_div_nxt = 2'h2;
      bus_div_nxt = 2'h2;
      periph_div_nxt = 2'h2;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      clock_mode <= 3'h0;
      pll1_run <= 1'b0;
      pll2_run <= 1'b0;
      phase_lag_en <= 1'b0;
      clk_from_pin <= 1'b0;
      crystal_osc_en <= 1'b0;
      ext_clock_driven <= 1'b0;
      clock_pause_req <= 1'b0;
      clkout_drive_en <= 1'b0;
      core_divider <= 2'h0;
      bus_divider <= 2'h0;
      periph_divider <= 2'h0;
      pll2_mult <= 2'h0;
      ratio_change_pending <= 1'b0;
      wdt_start <= 1'b0;
      wdt_flag_suppress <= 1'b0;
    end else begin
      // unmapped reads return zero
      reg_rdata <= (reg_rd && hit) ? ratio_r : 8'h00;
      clock_mode <= m;
      pll1_run <= mode_valid_r && p1_on;
      pll2_run <= mode_valid_r && p2_on;
      phase_lag_en <= mode_valid_r && (m == `CMRC_MODE5) && p1_on;
      clk_from_pin <= from_pin_nxt;
      crystal_osc_en <= crystal_nxt;
      ext_clock_driven <= driven_nxt;
      clock_pause_req <= pause_nxt;
      clkout_drive_en <= mode_valid_r && !pin_clock_mode(m)
                         && !active_r[`CMRC_BIT_CLKOUT_TRI];
      core_divider <= core_div_nxt;
      bus_divider <= bus_div_nxt;
      periph_divider <= periph_div_nxt;
      pll2_mult <= p2_on ? fr[3:2] : 2'h0;
      ratio_change_pending <= pending_r;
      wdt_start <= wr_hit;
      // an overflow beaten by a write applies nothing, so it is not masked
      wdt_flag_suppress <= pending_r && wdt_overflow && !wr_hit;
    end
  end

endmodule // cmrc_top

/* verilog/cmrc_map.vh */
/*
 * constants for the clock mode and ratio control block: register offset,
 * field positions, power-on values per clock mode, mode codes.
 * assumes inclusion by bare name from design files.
 */
`ifndef CMRC_MAP_VH
`define CMRC_MAP_VH

// ==========================================================
// register map
`define CMRC_ADDR_W 32
`define CMRC_RATIO_ADDR 32'hfffffe90

// ==========================================================
// field positions
`define CMRC_BIT_PLL2_DIS 7
`define CMRC_BIT_PLL1_DIS 6
`define CMRC_BIT_CLKOUT_TRI 5
`define CMRC_BIT_RSVD 4
`define CMRC_RATIO_MSB 3
`define CMRC_RATIO_LSB 0

// ==========================================================
// power-on values per mode
`define CMRC_INIT_M01 8'h00
`define CMRC_INIT_M2 8'h40
`define CMRC_INIT_M3 8'h60
`define CMRC_INIT_M45 8'ha6
`define CMRC_INIT_M6 8'he0

// ==========================================================
// mode codes and ratio codes
`define CMRC_MODE0 3'h0
`define CMRC_MODE1 3'h1
`define CMRC_MODE2 3'h2
`define CMRC_MODE3 3'h3
`define CMRC_MODE4 3'h4
`define CMRC_MODE5 3'h5
`define CMRC_MODE6 3'h6
`define CMRC_RATIO_QUARTER 4'h0
`define CMRC_RATIO_UNITY 4'hf

// ==========================================================
// power-on timing: count value at which the synchronised straps are latched
`define CMRC_POR_LOAD_CNT 2'h1

`endif

/* bench/cmrc_straps.sv */
/* strap model: mode pins and pause/select pin as the board drives them.
   assumes the bench picks the wanted mode while reset is low. */
`timescale 1ns/10ps
module cmrc_straps (
  input wire clock,
  input wire rst_n,
  input wire [2:0] mode_want,
  input wire sel_want,
  output logic [2:0] mode_select_pins,
  output logic pause_req_or_osc_select
);
  // straps move only under reset, and pattern 111 is never offered;
  // mode 5 is offered for test although an ordinary board straps mode 4
  always @(posedge clock) begin
    if (!rst_n && mode_want != 3'h7) begin
      mode_select_pins <= mode_want;
      pause_req_or_osc_select <= sel_want;
    end
  end
endmodule // cmrc_straps

/* bench/cmrc_asserts.sv */
/* assertions on the ports of cmrc_top.
   assumes a bind from the bench top; one clock domain. */
`timescale 1ns/10ps
`include "cmrc_map.vh"
module cmrc_asserts #(
  parameter ADDR_W = 32
) (
  input wire clock,
  input wire rst_n,
  input wire wdt_overflow,
  input wire [ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [2:0] clock_mode,
  input wire pll1_run,
  input wire pll2_run,
  input wire phase_lag_en,
  input wire crystal_osc_en,
  input wire ext_clock_driven,
  input wire clkout_drive_en,
  input wire ratio_change_pending,
  input wire wdt_start,
  input wire wdt_flag_suppress
);
  // ==========================================
  // checks
  wire hit = reg_addr == `CMRC_RATIO_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  lag_mode5_a: assert property (phase_lag_en |-> clock_mode == 3'h5)
    else $error("phase lag outside mode 5");
  lag_on_a: assert property ((clock_mode == 3'h5 && pll1_run) [*2] |-> phase_lag_en)
    else $error("no phase lag in mode 5");
  lag_drop_a: assert property ((clock_mode == 3'h5 && !pll1_run) [*2] |-> !phase_lag_en)
    else $error("phase lag with pll1 off");
  no_pll2_a: assert property (clock_mode[2] |-> !pll2_run)
    else $error("pll2 runs in pin clock mode");
  mode6_idle_a: assert property (clock_mode == 3'h6 |-> !pll1_run)
    else $error("pll1 runs in mode 6");
  pin_src_a: assert property ((crystal_osc_en || ext_clock_driven || clkout_drive_en)
    |-> !clock_mode[2])
    else $error("crystal path used in modes 4 to 6");
  osc_pair_a: assert property (!(crystal_osc_en && ext_clock_driven))
    else $error("crystal and driven clock both selected");
  rd_fixed_a: assert property (reg_rd && hit |=> !reg_rdata[4]
    && (!clock_mode[2] || reg_rdata[7] && reg_rdata[5]))
    else $error("reserved or fixed bit read wrong");
  rd_bit6_a: assert property (reg_rd && hit && clock_mode inside {3'h2, 3'h3, 3'h6}
    |=> reg_rdata[6])
    else $error("pll1 disable bit not read as 1");
  wdt_kick_a: assert property (reg_wr && hit |=> wdt_start)
    else $error("write did not start watchdog");
  apply_a: assert property (ratio_change_pending && wdt_overflow && !reg_wr
    |=> wdt_flag_suppress ##1 !wdt_flag_suppress)
    else $error("overflow flags not suppressed");
  hold_a: assert property (ratio_change_pending && !wdt_overflow && !$past(wdt_overflow)
    |=> $stable(pll1_run))
    else $error("pll state moved before overflow");
endmodule // cmrc_asserts

/* bench/cmrc_top_test.sv */
/* self-checking bench for cmrc_top: per-mode table, then mode 5, 6 and 3 cases.
   assumes the strap model and the checker are compiled before it. */
`timescale 1ns/10ps
`include "cmrc_map.vh"
module cmrc_top_test;
  logic clock = 0, rst_n = 0, wdt_overflow = 0, reg_wr = 0, reg_rd = 0, sel = 0;
  logic [2:0] m = 0;
  logic [31:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, rd;
  wire [7:0] reg_rdata;
  wire [2:0] mode_select_pins, clock_mode;
  wire [1:0] core_divider, bus_divider, periph_divider, pll2_mult;
  wire pause_req_or_osc_select, pll1_run, pll2_run, phase_lag_en, clk_from_pin;
  wire crystal_osc_en, ext_clock_driven, clock_pause_req, clkout_drive_en;
  int mismatches = 0, n_checks = 0, cyc = 0;
  // init value, write value, read back; one row per mode
  logic [23:0] rows [7] = '{24'h000000, 24'h000000, 24'h400040, 24'h602060,
    24'ha605a5, 24'ha605a5, 24'he00fef};
  cmrc_straps straps (.clock, .rst_n, .mode_want(m), .sel_want(sel), .mode_select_pins,
    .pause_req_or_osc_select);
  cmrc_top DUT (.clock, .rst_n, .mode_select_pins, .pause_req_or_osc_select, .wdt_overflow,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clock_mode, .pll1_run, .pll2_run,
    .phase_lag_en, .clk_from_pin, .crystal_osc_en, .ext_clock_driven, .clock_pause_req,
    .clkout_drive_en, .core_divider, .bus_divider, .periph_divider, .pll2_mult,
    .ratio_change_pending(), .wdt_start(), .wdt_flag_suppress());
  initial forever #25 clock = ~clock;
  // ==========================================
  // tasks
  task check(input string what, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // every driver starts on a rising edge and ends just past its last edge,
  // so the results it leaves behind are read settled
  task wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rdr(input logic [31:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  // straps change only inside reset, so every mode gets a fresh power-on
  task boot(input logic [2:0] mm, input logic s);
    @(posedge clock);
    rst_n <= 1'b0;
    m <= mm;
    sel <= s;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task kick;
    @(posedge clock);
    wdt_overflow <= 1'b1;
    @(posedge clock);
    wdt_overflow <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task status(input logic [2:0] mm, input logic s);
    logic [7:0] e, g;
    e = {1'b0, mm[2], !mm[2] && s, !mm[2] && !s, mm[2] && s,
      !(mm inside {3'h2, 3'h3, 3'h6}), !mm[2], mm == 3'h5};
    g = {1'b0, clk_from_pin, crystal_osc_en, ext_clock_driven, clock_pause_req,
      pll1_run, pll2_run, phase_lag_en};
    check("status", e, g);
    check("mode", {5'h0, mm}, {5'h0, clock_mode});
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop;
    end
  end
  // ==========================================
  // sequence
  initial begin
    for (int i = 0; i < 7; i++) begin
      boot(i[2:0], i[0]);
      status(i[2:0], i[0]);
      rdr(`CMRC_RATIO_ADDR);
      check("init", rows[i][23:16], rd);
      wr(`CMRC_RATIO_ADDR, rows[i][15:8]);
      rdr(`CMRC_RATIO_ADDR);
      check("readback", rows[i][7:0], rd);
      kick;
      check("drive", {7'h0, !i[2] && !rows[i][5]}, {7'h0, clkout_drive_en});
      $display("mode %0d done", i);
    end
    boot(3'h5, 1'b0);
    wr(`CMRC_RATIO_ADDR, 8'h46);
    check("pll1 held", 8'h01, {7'h0, pll1_run});
    kick;
    check("lag off", 8'h00, {6'h0, pll1_run, phase_lag_en});
    kick;
    wr(32'hfffffe94, 8'h00);
    rdr(32'hfffffe94);
    check("unmapped", 8'h00, rd);
    rdr(`CMRC_RATIO_ADDR);
    check("kept", 8'he6, rd);
    $display("mode 5 case done");
    boot(3'h6, 1'b1);
    wr(`CMRC_RATIO_ADDR, 8'h0f);
    kick;
    check("unity", 8'h00, {2'h0, core_divider, bus_divider, periph_divider});
    wr(`CMRC_RATIO_ADDR, 8'h00);
    kick;
    check("quarter", 8'h2a, {2'h0, core_divider, bus_divider, periph_divider});
    wr(`CMRC_RATIO_ADDR, 8'h09);
    kick;
    check("mixed", 8'h06, {2'h0, core_divider, bus_divider, periph_divider});
    $display("mode 6 case done");
    boot(3'h3, 1'b1);
    wr(`CMRC_RATIO_ADDR, 8'h6c);
    kick;
    check("pll2 on", 8'hc2, {pll2_mult, core_divider, bus_divider, periph_divider});
    wr(`CMRC_RATIO_ADDR, 8'hec);
    kick;
    check("pll2 off", 8'h02, {pll2_mult, core_divider, bus_divider, periph_divider});
    $display("mode 3 case done");
    report_and_stop;
  end
endmodule // cmrc_top_test

bind cmrc_top cmrc_asserts #(.ADDR_W(ADDR_W)) chk (.clock(clock), .rst_n(rst_n),
  .wdt_overflow(wdt_overflow), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clock_mode(clock_mode), .pll1_run(pll1_run), .pll2_run(pll2_run),
  .phase_lag_en(phase_lag_en), .crystal_osc_en(crystal_osc_en),
  .ext_clock_driven(ext_clock_driven), .clkout_drive_en(clkout_drive_en),
  .ratio_change_pending(ratio_change_pending), .wdt_start(wdt_start),
  .wdt_flag_suppress(wdt_flag_suppress));
